// ### logic/aqs_consts.svh
// Constants for the two-queue conversion sequencer
`ifndef AQS_CONSTS_SVH
`define AQS_CONSTS_SVH
// ---------------------------------------------------------------
// Table geometry and command word fields
// ---------------------------------------------------------------
`define AQS_TABLE_DEPTH   40
`define AQS_PTR_W         6
`define AQS_ENTRY_W       10
`define AQS_RESULT_W      10
`define AQS_EOQ_CHANNEL   6'h3F
`define AQS_PAUSE_BIT     6
`define AQS_BYPASS_BIT    7
`define AQS_SAMPLE_LSB    8
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define AQS_ADDR_W        12
`define AQS_OFF_CTRL1     12'h000
`define AQS_OFF_CTRL2     12'h004
`define AQS_OFF_START2    12'h008
`define AQS_OFF_STATUS    12'h00C
`define AQS_OFF_FLAGS     12'h010
`define AQS_OFF_TABLE     12'h100
`define AQS_OFF_RESULT    12'h200
`define AQS_OFF_WIN_END   12'h0A0
// ---------------------------------------------------------------
// Control fields and operating mode codes
// ---------------------------------------------------------------
`define AQS_SSE_BIT       3
`define AQS_RESUME_BIT    4
`define AQS_MODE_OFF      3'h0
`define AQS_MODE_SW_SS    3'h1
`define AQS_MODE_RISE_SS  3'h2
`define AQS_MODE_FALL_SS  3'h3
`define AQS_MODE_SW_CS    3'h4
`define AQS_MODE_RISE_CS  3'h5
`define AQS_MODE_FALL_CS  3'h6
`define AQS_MODE_RSVD     3'h7
// Flag bits: cf1 cf2 pf1 pf2 tor1 tor2
`define AQS_FLAGS_W       6
`define AQS_F_CF1         0
`define AQS_F_CF2         1
`define AQS_F_PF1         2
`define AQS_F_PF2         3
`define AQS_F_TOR1        4
`define AQS_F_TOR2        5
`define AQS_START2_RESET  6'h00
`endif

// ### logic/aqs_pkg.sv
// Types shared by the conversion sequencer
package aqs_pkg;
  typedef enum logic [2:0] {
    AQS_IDLE,
    AQS_ACTIVE,
    AQS_PAUSED,
    AQS_SUSPENDED,
    AQS_PENDING
  } aqs_qstate_t;
endpackage

// ### logic/aqs_sequencer.sv
// Two-queue conversion sequencer with APB register access
`timescale 1ns/1ps
`include "aqs_consts.svh"

// Overview of operation
// - Queue 1 always wins the converter over queue 2.
// - With both queues idle, a trigger starts its own queue.
// - Queue 2 trigger during queue 1 run waits as trigger pending.
// - Extra queue 2 triggers while pending set the overrun flag.
// - Queue 1 trigger aborts a running queue 2 conversion; queue 2 suspended.
// - Queue 2 triggers while suspended set the overrun flag.
// - Suspended queue 2 resumes after queue 1; resume bit picks entry.
// - Same-cycle triggers start queue 1 and leave queue 2 pending.
// - Entry with pause bit converts, then paused state and pause flag.
// - Trigger type and scan kind come from the queue's mode only.
// - After a pause execution continues with the next entry only.
// - Triggers during a running subqueue only set the overrun flag.
// - Continuous mode restarts at the queue's first entry after completion.
// - First entry with channel 63 completes the queue without converting.
// - Queue 2 start pointer beyond the table ends queue 2 at once.
// - Queue 1 ends on reaching the queue 2 start pointer.
// - Pause followed by end of queue: both flags, status idle.
// - Pause and end of queue in one entry: end wins, no conversion.
// - Disabled or reserved mode queues ignore all triggers.
// - No wait states on table accesses when both queues disabled.
// - Command table holds forty entries, one channel each.
// - Single-scan enable clears when the queue scan completes in a single-scan mode; continuous modes leave it set.
module aqs_sequencer
  import aqs_pkg::*;
#(
  parameter int DEPTH = `AQS_TABLE_DEPTH
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     reset_n_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [`AQS_ADDR_W-1:0]   paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  input  wire logic                     trig1_in,
  input  wire logic                     trig2_in,
  output logic                          conv_req_out,
  output logic      [5:0]               conv_channel_out,
  output logic      [1:0]               conv_sample_out,
  output logic                          conv_bypass_out,
  output logic                          conv_abort_out,
  input  wire logic                     conv_done_in,
  input  wire logic [`AQS_RESULT_W-1:0] conv_result_in
);

  // -------------------------------------------------------------
  // Storage and state
  // -------------------------------------------------------------
  logic [`AQS_ENTRY_W-1:0]  conversion_command_entry [DEPTH];
  logic [`AQS_RESULT_W-1:0] result_word [DEPTH];
  logic [2:0]               queue1_operating_mode;
  logic [2:0]               queue2_operating_mode;
  logic                     queue1_single_scan_enable;
  logic                     queue2_single_scan_enable;
  logic                     resume_at_abort;
  logic [`AQS_PTR_W-1:0]    queue2_start_pointer;
  aqs_qstate_t              q1_state;
  aqs_qstate_t              q2_state;
  logic [`AQS_PTR_W-1:0]    ptr1;
  logic [`AQS_PTR_W-1:0]    ptr2;
  logic [`AQS_PTR_W-1:0]    sub2_start;
  logic                     owner2;
  logic [`AQS_FLAGS_W-1:0]  flags;
  logic                     trig1_q;
  logic                     trig2_q;
  logic                     wait_q;

  // -------------------------------------------------------------
  // Helper functions
  // -------------------------------------------------------------
  function automatic logic is_off(input logic [2:0] mode);
    return (mode == `AQS_MODE_OFF) || (mode == `AQS_MODE_RSVD);
  endfunction

  function automatic logic is_sw(input logic [2:0] mode);
    return (mode == `AQS_MODE_SW_SS) || (mode == `AQS_MODE_SW_CS);
  endfunction

  function automatic logic is_single(input logic [2:0] mode);
    return (mode == `AQS_MODE_SW_SS) || (mode == `AQS_MODE_RISE_SS) ||
           (mode == `AQS_MODE_FALL_SS);
  endfunction

  // Software modes re-trigger whenever the queue rests, single-scan only with its enable set
  function automatic logic mode_trig(input logic [2:0] mode,
                                     input logic sse, input logic rise,
                                     input logic fall, input logic rest);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      `AQS_MODE_SW_SS:   hit = sse & rest;
      `AQS_MODE_RISE_SS: hit = sse & rise;
      `AQS_MODE_FALL_SS: hit = sse & fall;
      `AQS_MODE_SW_CS:   hit = rest;
      `AQS_MODE_RISE_CS: hit = rise;
      `AQS_MODE_FALL_CS: hit = fall;
      default:           hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic rests(input aqs_qstate_t st);
    return (st == AQS_IDLE) || (st == AQS_PAUSED);
  endfunction

  // End of queue: past the table, channel 63, or queue 1 hitting
  // the queue 2 start
  function automatic logic at_eoq(input logic q2,
                                  input logic [`AQS_PTR_W-1:0] idx);
    logic end_of_queue_code;
    end_of_queue_code = 1'b1;
    if (idx < `AQS_PTR_W'(DEPTH)) begin
      end_of_queue_code = (conversion_command_entry[idx][5:0] == `AQS_EOQ_CHANNEL);
    end
    if (!q2 && idx == queue2_start_pointer) begin
      end_of_queue_code = 1'b1;
    end
    return end_of_queue_code;
  endfunction

  // -------------------------------------------------------------
  // Event decode
  // -------------------------------------------------------------
  logic                  off1;
  logic                  off2;
  logic                  t1;
  logic                  t2;
  logic                  t1_start;
  logic                  abort_q2;
  logic                  done_ok;
  logic [`AQS_PTR_W-1:0] cur_ptr;
  logic [`AQS_PTR_W-1:0] nxt_ptr;
  logic                  cur_pause;
  logic                  cur_single;
  logic                  run1;
  logic [`AQS_PTR_W-1:0] fetch_ptr;

  assign run1 = (q1_state == AQS_ACTIVE) && !off1;
  assign fetch_ptr = run1 ? ptr1 : ptr2;
  assign off1 = is_off(queue1_operating_mode);
  assign off2 = is_off(queue2_operating_mode);
  assign t1 = !off1 && mode_trig(queue1_operating_mode,
      queue1_single_scan_enable, trig1_in & ~trig1_q,
      ~trig1_in & trig1_q, rests(q1_state));
  assign t2 = !off2 && mode_trig(queue2_operating_mode,
      queue2_single_scan_enable, trig2_in & ~trig2_q,
      ~trig2_in & trig2_q, rests(q2_state));
  assign t1_start = t1 && rests(q1_state);
  assign abort_q2 = t1_start && (q2_state == AQS_ACTIVE);
  assign cur_ptr = owner2 ? ptr2 : ptr1;
  assign nxt_ptr = cur_ptr + `AQS_PTR_W'(1);
  assign cur_pause = conversion_command_entry[cur_ptr][`AQS_PAUSE_BIT];
  assign cur_single = is_single(owner2 ? queue2_operating_mode
                                       : queue1_operating_mode);
  assign done_ok = conv_req_out && conv_done_in && !(owner2 && abort_q2) &&
                   !(owner2 ? off2 : off1);

  // -------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------
  logic                  tbl_hit;
  logic                  res_hit;
  logic                  reg_hit;
  logic [`AQS_PTR_W-1:0] win_idx;
  logic                  wr_en;
  logic [31:0]           rd_data;

  assign win_idx = paddr_in[`AQS_PTR_W+1:2];
  assign tbl_hit = (paddr_in >= `AQS_OFF_TABLE) &&
                   (paddr_in < `AQS_OFF_TABLE + `AQS_OFF_WIN_END);
  assign res_hit = (paddr_in >= `AQS_OFF_RESULT) &&
                   (paddr_in < `AQS_OFF_RESULT + `AQS_OFF_WIN_END);
  assign reg_hit = (paddr_in == `AQS_OFF_CTRL1) ||
                   (paddr_in == `AQS_OFF_CTRL2) ||
                   (paddr_in == `AQS_OFF_START2) ||
                   (paddr_in == `AQS_OFF_STATUS) ||
                   (paddr_in == `AQS_OFF_FLAGS);
  assign wr_en = psel_in && penable_in && pready_out && pwrite_in;

  always_comb begin
    rd_data = 32'h0000_0000;
    if (tbl_hit) begin
      rd_data[`AQS_ENTRY_W-1:0] = conversion_command_entry[win_idx];
    end else if (res_hit) begin
      rd_data[`AQS_RESULT_W-1:0] = result_word[win_idx];
    end else begin
      unique case (paddr_in)
        // Single-scan enable always reads as zero
        `AQS_OFF_CTRL1:  rd_data[2:0] = queue1_operating_mode;
        `AQS_OFF_CTRL2: begin
          rd_data[2:0] = queue2_operating_mode;
          rd_data[`AQS_RESUME_BIT] = resume_at_abort;
        end
        `AQS_OFF_START2: rd_data[`AQS_PTR_W-1:0] = queue2_start_pointer;
        `AQS_OFF_STATUS: rd_data[5:0] = {q2_state, q1_state};
        `AQS_OFF_FLAGS:  rd_data[`AQS_FLAGS_W-1:0] = flags;
        default:         rd_data = 32'h0000_0000;
      endcase
    end
  end

  // -------------------------------------------------------------
  // APB answer
  // -------------------------------------------------------------
  // Table windows wait one cycle while a queue may use them
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      wait_q      <= 1'b0;
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      wait_q      <= 1'b0;
      if (psel_in && !penable_in) begin
        if ((tbl_hit || res_hit) && !(off1 && off2)) begin
          wait_q <= 1'b1;
        end else begin
          pready_out  <= 1'b1;
          pslverr_out <= !(tbl_hit || res_hit || reg_hit);
          prdata_out  <= rd_data;
        end
      end else if (wait_q) begin
        pready_out <= 1'b1;
        prdata_out <= rd_data;
      end
    end
  end

  // -------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      queue1_operating_mode <= `AQS_MODE_OFF;
      queue2_operating_mode <= `AQS_MODE_OFF;
      resume_at_abort       <= 1'b0;
      queue2_start_pointer  <= `AQS_START2_RESET;
    end else if (wr_en) begin
      if (paddr_in == `AQS_OFF_CTRL1) begin
        queue1_operating_mode <= pwdata_in[2:0];
      end
      if (paddr_in == `AQS_OFF_CTRL2) begin
        queue2_operating_mode <= pwdata_in[2:0];
        resume_at_abort       <= pwdata_in[`AQS_RESUME_BIT];
      end
      if (paddr_in == `AQS_OFF_START2) begin
        queue2_start_pointer <= pwdata_in[`AQS_PTR_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (wr_en && tbl_hit) begin
      conversion_command_entry[win_idx] <= pwdata_in[`AQS_ENTRY_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (done_ok) begin
      result_word[cur_ptr] <= conv_result_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trig1_q <= 1'b0;
      trig2_q <= 1'b0;
    end else begin
      trig1_q <= trig1_in;
      trig2_q <= trig2_in;
    end
  end

  // -------------------------------------------------------------
  // Queue sequencing
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q1_state                  <= AQS_IDLE;
      q2_state                  <= AQS_IDLE;
      ptr1                      <= '0;
      ptr2                      <= '0;
      sub2_start                <= '0;
      owner2                    <= 1'b0;
      flags                     <= '0;
      queue1_single_scan_enable <= 1'b0;
      queue2_single_scan_enable <= 1'b0;
      conv_req_out              <= 1'b0;
      conv_channel_out          <= 6'h00;
      conv_sample_out           <= 2'h0;
      conv_bypass_out           <= 1'b0;
      conv_abort_out            <= 1'b0;
    end else begin
      conv_abort_out <= 1'b0;
      // Write-one-to-clear; any set below overrides the clear
      if (wr_en && paddr_in == `AQS_OFF_FLAGS) begin
        flags <= flags & ~pwdata_in[`AQS_FLAGS_W-1:0];
      end
      if (wr_en && paddr_in == `AQS_OFF_CTRL1) begin
        queue1_single_scan_enable <= pwdata_in[`AQS_SSE_BIT];
      end
      if (wr_en && paddr_in == `AQS_OFF_CTRL2) begin
        queue2_single_scan_enable <= pwdata_in[`AQS_SSE_BIT];
      end

      // Queue 1 triggers
      if (off1) begin
        q1_state <= AQS_IDLE;
      end else if (t1) begin
        if (rests(q1_state)) begin
          q1_state <= AQS_ACTIVE;
          if (q1_state == AQS_IDLE) begin
            ptr1 <= '0;
          end
        end else if (!is_sw(queue1_operating_mode)) begin
          flags[`AQS_F_TOR1] <= 1'b1;
        end
      end

      // Queue 2 triggers, suspension and release
      if (off2) begin
        q2_state <= AQS_IDLE;
      end else if (abort_q2) begin
        q2_state <= AQS_SUSPENDED;
      end else if (t2) begin
        if (rests(q2_state)) begin
          // Queue 1 busy or starting: wait
          q2_state <= (q1_state == AQS_ACTIVE || t1_start) ?
                      AQS_PENDING : AQS_ACTIVE;
          if (q2_state == AQS_IDLE) begin
            ptr2       <= queue2_start_pointer;
            sub2_start <= queue2_start_pointer;
          end else begin
            sub2_start <= ptr2;
          end
        end else if (!is_sw(queue2_operating_mode)) begin
          flags[`AQS_F_TOR2] <= 1'b1;
        end
      end else if (q1_state != AQS_ACTIVE && !t1_start &&
                   (q2_state == AQS_PENDING ||
                    q2_state == AQS_SUSPENDED)) begin
        q2_state <= AQS_ACTIVE;
        if (q2_state == AQS_SUSPENDED && !resume_at_abort) begin
          ptr2 <= sub2_start;
        end
      end

      // Conversion engine
      if (conv_req_out) begin
        if ((owner2 && (abort_q2 || off2)) || (!owner2 && off1)) begin
          conv_req_out   <= 1'b0;
          conv_abort_out <= 1'b1;
        end else if (done_ok) begin
          conv_req_out <= 1'b0;
          if (owner2) begin
            ptr2 <= nxt_ptr;
          end else begin
            ptr1 <= nxt_ptr;
          end
          if (cur_pause) begin
            flags[owner2 ? `AQS_F_PF2 : `AQS_F_PF1] <= 1'b1;
          end
          if (at_eoq(owner2, nxt_ptr)) begin
            // Pause just before the end still shows idle
            flags[owner2 ? `AQS_F_CF2 : `AQS_F_CF1] <= 1'b1;
            if (owner2) begin
              q2_state <= AQS_IDLE;
              if (cur_single) queue2_single_scan_enable <= 1'b0;
            end else begin
              q1_state <= AQS_IDLE;
              if (cur_single) queue1_single_scan_enable <= 1'b0;
            end
          end else if (cur_pause) begin
            if (owner2) begin
              q2_state <= AQS_PAUSED;
            end else begin
              q1_state <= AQS_PAUSED;
            end
          end
        end
      end else if (run1 ||
                   (q2_state == AQS_ACTIVE && !off2 && !abort_q2)) begin
        // Queue 1 is served first whenever it is active
        if (at_eoq(!run1, fetch_ptr)) begin
          // End of queue wins over a pause in the same entry
          if (run1) begin
            flags[`AQS_F_CF1] <= 1'b1;
            q1_state <= AQS_IDLE;
            if (is_single(queue1_operating_mode)) begin
              queue1_single_scan_enable <= 1'b0;
            end
          end else begin
            flags[`AQS_F_CF2] <= 1'b1;
            q2_state <= AQS_IDLE;
            if (is_single(queue2_operating_mode)) begin
              queue2_single_scan_enable <= 1'b0;
            end
          end
        end else begin
          owner2           <= !run1;
          conv_req_out     <= 1'b1;
          conv_channel_out <= conversion_command_entry[fetch_ptr][5:0];
          conv_bypass_out  <= conversion_command_entry[fetch_ptr]
              [`AQS_BYPASS_BIT];
          conv_sample_out  <= conversion_command_entry[fetch_ptr]
              [`AQS_SAMPLE_LSB+:2];
        end
      end
    end
  end

endmodule // aqs_sequencer

// ### tb/aqs_seq_assertions.sv
// Port-level assertions for the conversion sequencer
`timescale 1ns/1ps
`include "aqs_consts.svh"
module aqs_seq_checker (
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        conv_req_out,
  input wire logic [5:0]  conv_channel_out,
  input wire logic        conv_abort_out,
  input wire logic        conv_done_in
);
  // ----------------------------------------
  // Mode shadow snooped from completed writes
  // ----------------------------------------
  logic [2:0] m1;
  logic [2:0] m2;
  logic       both_off;
  logic       tbl;
  logic       hole;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      m1 <= 3'h0;
      m2 <= 3'h0;
    end else if (psel_in && penable_in && pready_out && pwrite_in) begin
      if (paddr_in == `AQS_OFF_CTRL1) m1 <= pwdata_in[2:0];
      if (paddr_in == `AQS_OFF_CTRL2) m2 <= pwdata_in[2:0];
    end
  end
  // Reserved mode counts as off
  assign both_off = (m1 == 3'h0 || m1 == 3'h7) && (m2 == 3'h0 || m2 == 3'h7);
  assign tbl = (paddr_in[11:8] == 4'h1 || paddr_in[11:8] == 4'h2)
               && paddr_in[7:0] < 8'hA0;
  assign hole = paddr_in[11:8] == 4'h1 && paddr_in[7:0] >= 8'hA0;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  a_req_held: assert property (conv_req_out && !conv_done_in |=>
    conv_abort_out || (conv_req_out && $stable(conv_channel_out)))
    else $error("request not held");
  a_abort_drops: assert property (conv_abort_out |-> !conv_req_out)
    else $error("request with abort");
  a_done_gap: assert property (conv_req_out && conv_done_in |=>
    !conv_req_out) else $error("request held after done");
  a_no_eoq_conv: assert property (conv_req_out |->
    conv_channel_out != `AQS_EOQ_CHANNEL)
    else $error("end code converted");
  a_off_idle: assert property (both_off && $past(both_off) |->
    !conv_req_out) else $error("conversion while off");
  a_zero_wait: assert property ($rose(penable_in) && psel_in && both_off
    |-> pready_out) else $error("wait state while off");
  a_one_wait: assert property ($rose(penable_in) && psel_in && tbl
    && !both_off |-> !pready_out ##1 pready_out)
    else $error("table latency wrong");
  a_err_hole: assert property (pready_out && hole |-> pslverr_out)
    else $error("hole accepted");
  c_abort: cover property (conv_abort_out);
  c_done: cover property (conv_req_out && conv_done_in);
  c_err: cover property (pslverr_out);
endmodule // aqs_seq_checker

bind aqs_sequencer aqs_seq_checker u_aqs_seq_checker (.clk_sys_in,
  .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .pready_out, .pslverr_out, .conv_req_out, .conv_channel_out,
  .conv_abort_out, .conv_done_in);

// ### tb/aqs_core_model.sv
// Behavioural model of the analog conversion core
`timescale 1ns/1ps
module aqs_core_model #(
  parameter int LAT = 20
) (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic       req_in,
  input  wire logic [5:0] channel_in,
  input  wire logic       abort_in,
  output logic            done_out,
  output logic [9:0]      result_out
);
  // ----------------------------------------
  // Conversion timer
  // ----------------------------------------
  int cnt;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt <= 0;
      done_out <= 1'b0;
      result_out <= 10'h000;
    end else if (!req_in || abort_in || done_out) begin
      cnt <= 0;
      done_out <= 1'b0;
      // Toggle result while idle so stale data shows
      result_out <= ~result_out;
    end else if (cnt == LAT) begin
      done_out <= 1'b1;
      result_out <= {4'hA, channel_in};
    end else begin
      cnt <= cnt + 1;
      result_out <= ~result_out;
    end
  end
endmodule // aqs_core_model

// ### tb/adc_queue_sequencer_bench.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "aqs_consts.svh"
module adc_queue_sequencer_bench;
  import aqs_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic        trig1_in = 1'b0;
  logic        trig2_in = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        conv_req_out;
  logic [5:0]  conv_channel_out;
  logic        conv_abort_out;
  logic        conv_done_in;
  logic [9:0]  conv_result_in;
  int          n_fail = 0;
  int          checked = 0;
  logic [31:0] r;
  logic        e;
  logic [9:0]  tbl [7] = '{10'h005, 10'h046, 10'h007, 10'h03F, 10'h009,
                          10'h00A, 10'h03F};
  aqs_sequencer u_aqs_sequencer (.clk_sys_in, .reset_n_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .trig1_in, .trig2_in, .conv_req_out,
    .conv_channel_out, .conv_sample_out(), .conv_bypass_out(),
    .conv_abort_out, .conv_done_in, .conv_result_in);
  aqs_core_model u_aqs_core_model (.clk_sys_in, .reset_n_in,
    .req_in(conv_req_out), .channel_in(conv_channel_out),
    .abort_in(conv_abort_out), .done_out(conv_done_in),
    .result_out(conv_result_in));
  always #4 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, x);
    checked++;
    if (seen !== x) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, x, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      finish_test();
    end
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic ex = 0);
    apb(1'b0, a, 32'h0000_0000);
    check("prdata", r, x);
    check("pslverr", {31'h0, e}, {31'h0, ex});
  endtask
  task poll(input logic [11:0] a, input logic [31:0] x);
    for (int k = 0; k < 60; k++) begin
      apb(1'b0, a, 32'h0000_0000);
      if (r === x) break;
    end
    check("poll", r, x);
    if (r !== x) finish_test();
  endtask
  task pulse(input logic t1, input logic t2);
    @(posedge clk_sys_in);
    trig1_in <= t1;
    trig2_in <= t2;
    repeat (2) @(posedge clk_sys_in);
    trig1_in <= 1'b0;
    trig2_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task req(input logic [5:0] ch, input logic drop);
    int n;
    n = 0;
    while (conv_req_out !== 1'b1 && n < 600) begin
      @(posedge clk_sys_in);
      n++;
    end
    check("channel", {26'h0, conv_channel_out}, {26'h0, ch});
    while (drop && conv_req_out !== 1'b0 && n < 600) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 600) begin
      n_fail++;
      finish_test();
    end
  endtask
  function automatic logic [31:0] st(aqs_qstate_t a, aqs_qstate_t b);
    return {26'h0, b, a};
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    rd(`AQS_OFF_STATUS, st(AQS_IDLE, AQS_IDLE));
    rd(`AQS_OFF_FLAGS, 32'h0000_0000);
    rd(`AQS_OFF_START2, 32'h0000_0000);
    rd(12'h020, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 7; i++) wr(12'(`AQS_OFF_TABLE + 4 * i), {22'h0, tbl[i]});
    wr(12'h19C, 32'h0000_03FF);
    rd(12'h19C, 32'h0000_03FF);
    rd(12'h1A0, 32'h0000_0000, 1'b1);
    rd(12'h104, 32'h0000_0046);
    wr(`AQS_OFF_START2, 32'h0000_0004);
    wr(`AQS_OFF_CTRL1, 32'h0000_000A);
    rd(`AQS_OFF_CTRL1, 32'h0000_0002);
    pulse(1'b1, 1'b0);
    req(6'h05, 1'b1);
    req(6'h06, 1'b1);
    poll(`AQS_OFF_STATUS, st(AQS_PAUSED, AQS_IDLE));
    rd(`AQS_OFF_FLAGS, 32'h0000_0004);
    pulse(1'b1, 1'b0);
    req(6'h07, 1'b1);
    poll(`AQS_OFF_STATUS, st(AQS_IDLE, AQS_IDLE));
    rd(`AQS_OFF_FLAGS, 32'h0000_0005);
    for (int i = 0; i < 3; i++)
      rd(12'(`AQS_OFF_RESULT + 4 * i), {22'h0, 4'hA, tbl[i][5:0]});
    pulse(1'b1, 1'b0);
    rd(`AQS_OFF_STATUS, st(AQS_IDLE, AQS_IDLE));
    wr(`AQS_OFF_FLAGS, 32'h0000_003F);
    wr(`AQS_OFF_CTRL1, 32'h0000_0005);
    wr(`AQS_OFF_CTRL2, 32'h0000_0005);
    pulse(1'b0, 1'b1);
    req(6'h09, 1'b0);
    pulse(1'b1, 1'b0);
    poll(`AQS_OFF_STATUS, st(AQS_ACTIVE, AQS_SUSPENDED));
    pulse(1'b0, 1'b1);
    req(6'h05, 1'b1);
    req(6'h06, 1'b1);
    req(6'h09, 1'b1);
    req(6'h0A, 1'b1);
    poll(`AQS_OFF_STATUS, st(AQS_PAUSED, AQS_IDLE));
    rd(`AQS_OFF_FLAGS, 32'h0000_0026);
    wr(`AQS_OFF_FLAGS, 32'h0000_003F);
    pulse(1'b1, 1'b1);
    poll(`AQS_OFF_STATUS, st(AQS_ACTIVE, AQS_PENDING));
    pulse(1'b0, 1'b1);
    req(6'h07, 1'b1);
    req(6'h09, 1'b1);
    req(6'h0A, 1'b1);
    poll(`AQS_OFF_STATUS, st(AQS_IDLE, AQS_IDLE));
    rd(`AQS_OFF_FLAGS, 32'h0000_0023);
    pulse(1'b1, 1'b0);
    req(6'h05, 1'b1);
    req(6'h06, 1'b1);
    wr(`AQS_OFF_FLAGS, 32'h0000_003F);
    wr(`AQS_OFF_START2, 32'h0000_0028);
    pulse(1'b0, 1'b1);
    poll(`AQS_OFF_FLAGS, 32'h0000_0002);
    rd(`AQS_OFF_STATUS, st(AQS_PAUSED, AQS_IDLE));
    wr(`AQS_OFF_CTRL2, 32'h0000_0000);
    pulse(1'b0, 1'b1);
    rd(`AQS_OFF_STATUS, st(AQS_PAUSED, AQS_IDLE));
    rd(`AQS_OFF_FLAGS, 32'h0000_0002);
    wr(`AQS_OFF_CTRL1, 32'h0000_0000);
    rd(`AQS_OFF_TABLE, 32'h0000_0005);
    finish_test();
  end
endmodule // adc_queue_sequencer_bench
